// *** bmc_defines.svh ***
`ifndef BMC_DEFINES_SVH
`define BMC_DEFINES_SVH
// clock and time base
`define BMC_CLK_HZ 50_000_000
`define BMC_MS_CYC (`BMC_CLK_HZ / 1000)
`define BMC_DEFER_MS 30
`define BMC_FLASH_MS 250
`define BMC_HOLD_MS 1000
`define BMC_POWER_ON_SELF_TEST_MS 10
// register byte offsets
`define BMC_OFS_CTRL 8'h00
`define BMC_OFS_STAT 8'h04
`define BMC_OFS_CFG_TO 8'h08
`define BMC_OFS_ACT_TO 8'h0C
`define BMC_OFS_SLOT0 8'h40
// slot word fields
`define BMC_GATE_LSB 0
`define BMC_TYPE_LSB 2
`define BMC_PWR_LSB 5
`define BMC_IVL_LSB 10
// control bits
`define BMC_CTRL_START_WH 0
`define BMC_CTRL_CFG_FLIP 1
// reset values and connectable packet type
`define BMC_CTRL_RST 32'h0000_0000
`define BMC_CFG_TO_RST 32'h0000_EA60
`define BMC_ACT_TO_RST 32'h0000_7530
`define BMC_SLOT_RST 32'h0000_0000
`define BMC_PT_CONN 3'h5
`endif

// *** bmc_pkg.sv ***
package bmc_pkg;
  // top-level modes
  typedef enum logic [3:0] {
    st_power_on_self_test = 4'b0001,
    st_warehouse = 4'b0010,
    st_config = 4'b0100,
    st_beacon = 4'b1000
  } bmc_mode_e;
  // per-slot gating
  typedef enum logic [1:0] {
    gate_off = 2'h0,
    gate_always = 2'h1,
    gate_active = 2'h2,
    gate_inactive = 2'h3
  } bmc_gate_e;
  // indicator sequencer
  typedef enum logic [3:0] {
    led_idle = 4'b0001,
    led_on = 4'b0010,
    led_gap = 4'b0100,
    led_hold = 4'b1000
  } bmc_led_e;
endpackage

// *** bmc_top.sv ***
// The register offsets and the Avalon-MM register port were decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "bmc_defines.svh"

// Function
// - beaconing runs up to ten slots, each with type, interval, power; default off
// - each slot gates off, always, active-only or inactive-only; default off
// - enabled slots under current gating merge into one interleaved sequence
// - beaconing starts in inactivity until an activity event arrives
// - activity event stops inactive slots, starts active slots, rebuilds sequence
// - colliding slots resolved by priority; loser deferred at least 30 ms
// - active-gated slots send only after activity, until activity timeout
// - always-gated slots send in both sub-modes
// - inactive-gated slots send only outside activity
// - connection accepted whenever a connectable advertisement is being sent
// - accelerometer interrupts masked while connected
// - config or activity timer runs during connection; expiry applied at disconnect
// - button press while connected terminates the connection
// - unexpired timer at disconnect resumes the mode where connection began
// - reset event returns to power-on self-test
// - configuration event moves beaconing or warehouse into configuration
// - flip source fires only on gravity going from minus Z to plus Z
// - configuration event flashes green twice
// - configuration timer started on entry; expiry moves to startup mode
// - configuration timeout flashes red twice
// - on/off toggles beaconing-warehouse; configuration goes to beaconing
// - on/off: green once into beaconing, red held out, red twice from config
// - startup mode after a passing self-test or config timeout is software selected; failed self-test enters configuration
// - activity entry starts activity timer; expiry returns to inactivity
// - lock disables on/off and moves to beaconing until reset
module bmc_top #(
  parameter int N_SLOT = 10,
  parameter int MS_CYC = `BMC_MS_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // avalon-mm slave
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // event pins
  input wire logic btn_press,
  input wire logic act_det,
  input wire logic grav_neg_z,
  input wire logic grav_pos_z,
  input wire logic cfg_src_evt,
  input wire logic onoff_evt,
  input wire logic lock_evt,
  input wire logic reset_evt,
  input wire logic conn_req,
  input wire logic conn_drop,
  input wire logic st_fail,
  // radio side
  output logic conn_accept,
  output logic conn_term,
  output logic accel_irq_mask,
  output logic tx_valid,
  output logic [3:0] tx_slot,
  output logic [2:0] tx_ptype,
  output logic [4:0] tx_power,
  // indicators
  output logic led_red,
  output logic led_green
);
  import bmc_pkg::*;

  // -----------------------------------------------------------
  // pin synchronisers and edges
  // -----------------------------------------------------------
  localparam int NP = 11;
  logic [NP-1:0] pin_raw;
  logic [NP-1:0] sync1;
  logic [NP-1:0] sync2;
  logic [NP-1:0] sync3;
  logic [NP-1:0] rise;
  assign pin_raw = {st_fail, conn_drop, conn_req, reset_evt, lock_evt,
    onoff_evt, cfg_src_evt, grav_pos_z, grav_neg_z, act_det, btn_press};

  // two-stage sync, third stage only for edge; one process owns each vector
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      sync1 <= {NP{1'b0}};
      sync2 <= {NP{1'b0}};
      sync3 <= {NP{1'b0}};
    end
    else
    begin
      sync1 <= pin_raw;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  genvar gp;
  generate
    for (gp = 0; gp < NP; gp++)
    begin : g_sync
      // rising edge of each synchronised pin
      assign rise[gp] = sync2[gp] & ~sync3[gp];
    end
  endgenerate

  logic btn_e, act_e, pos_e, cfg_src_e, onoff_e, lock_e, reset_e;
  logic req_e, drop_e, neg_lvl, fail_lvl;
  assign btn_e = rise[0];
  assign act_e = rise[1];
  assign neg_lvl = sync2[2];
  assign pos_e = rise[3];
  assign cfg_src_e = rise[4];
  assign onoff_e = rise[5];
  assign lock_e = rise[6];
  assign reset_e = rise[7];
  assign req_e = rise[8];
  assign drop_e = rise[9];
  assign fail_lvl = sync2[10];

  // -----------------------------------------------------------
  // millisecond enable
  // -----------------------------------------------------------
  logic [31:0] div_cnt;
  logic ms_tick;
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      div_cnt <= 32'h0000_0000;
    else if (div_cnt == 32'(MS_CYC - 1))
      div_cnt <= 32'h0000_0000;
    else
      div_cnt <= div_cnt + 32'h0000_0001;
  end
  assign ms_tick = (div_cnt == 32'(MS_CYC - 1));

  // -----------------------------------------------------------
  // registers
  // -----------------------------------------------------------
  logic [31:0] ctrl, cfg_to, act_to;
  logic [31:0] slot_cfg [N_SLOT];
  logic bus_ack;
  bmc_mode_e mode;
  logic active, conn_open, locked;
  bmc_led_e led_st;

  assign avs_waitrequest = (avs_read | avs_write) & ~bus_ack;

  // one wait cycle per access
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      bus_ack <= 1'b0;
    else
      bus_ack <= (avs_read | avs_write) & ~bus_ack;
  end

  // writes land on the acknowledging edge
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      ctrl <= `BMC_CTRL_RST;
      cfg_to <= `BMC_CFG_TO_RST;
      act_to <= `BMC_ACT_TO_RST;
      for (int i = 0; i < N_SLOT; i++)
        slot_cfg[i] <= `BMC_SLOT_RST;
    end
    else if (avs_write && bus_ack)
    begin
      if (avs_address == `BMC_OFS_CTRL)
        ctrl <= avs_writedata & 32'h0000_0003;
      else if (avs_address == `BMC_OFS_CFG_TO)
        cfg_to <= avs_writedata;
      else if (avs_address == `BMC_OFS_ACT_TO)
        act_to <= avs_writedata;
      else
        for (int i = 0; i < N_SLOT; i++)
          if (avs_address == 8'(`BMC_OFS_SLOT0 + 4 * i))
            slot_cfg[i] <= avs_writedata;
    end
  end

  // read data, unmapped reads zero
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      avs_readdata <= 32'h0000_0000;
    else if (avs_read && !bus_ack)
    begin
      if (avs_address == `BMC_OFS_CTRL)
        avs_readdata <= ctrl;
      else if (avs_address == `BMC_OFS_STAT)
        avs_readdata <= {21'h0, led_st, locked, conn_open, active, mode};
      else if (avs_address == `BMC_OFS_CFG_TO)
        avs_readdata <= cfg_to;
      else if (avs_address == `BMC_OFS_ACT_TO)
        avs_readdata <= act_to;
      else
      begin
        avs_readdata <= 32'h0000_0000;
        for (int i = 0; i < N_SLOT; i++)
          if (avs_address == 8'(`BMC_OFS_SLOT0 + 4 * i))
            avs_readdata <= slot_cfg[i];
      end
    end
  end

  // -----------------------------------------------------------
  // scheduler
  // -----------------------------------------------------------
  function automatic logic gate_on(input logic [1:0] g, input logic act);
    gate_on = (g == gate_always) || (g == gate_active && act)
      || (g == gate_inactive && !act);
  endfunction

  function automatic logic [3:0] first_one(input logic [N_SLOT-1:0] v);
    first_one = 4'h0;
    for (int i = N_SLOT - 1; i >= 0; i--)
      if (v[i])
        first_one = 4'(i);
  endfunction

  logic [21:0] slot_cnt [N_SLOT];
  logic [N_SLOT-1:0] en, due, conn_adv;
  logic [3:0] win;
  logic rebuild, prev_active;
  bmc_mode_e prev_mode;
  logic [1:0] tx_gate;

  genvar gs;
  generate
    for (gs = 0; gs < N_SLOT; gs++)
    begin : g_slot
      logic [21:0] ivl;
      assign ivl = slot_cfg[gs][`BMC_IVL_LSB +: 22];
      assign en[gs] = (mode == st_beacon) && !conn_open && (ivl != 22'h0)
        && gate_on(slot_cfg[gs][`BMC_GATE_LSB +: 2], active);
      assign due[gs] = en[gs] && (slot_cnt[gs] == 22'h0);
      assign conn_adv[gs] = en[gs]
        && (slot_cfg[gs][`BMC_TYPE_LSB +: 3] == `BMC_PT_CONN);
      // per-slot interval countdown in ms
      always_ff @(posedge clk)
      begin
        if (!rst_b)
          slot_cnt[gs] <= 22'h0;
        else if (ms_tick)
        begin
          if (rebuild || !en[gs])
            slot_cnt[gs] <= 22'h0;
          else if (due[gs] && win == 4'(gs))
            slot_cnt[gs] <= ivl - 22'h1;
          else if (due[gs])
            slot_cnt[gs] <= 22'(`BMC_DEFER_MS);
          else
            slot_cnt[gs] <= slot_cnt[gs] - 22'h1;
        end
      end
    end
  endgenerate

  assign win = first_one(due);

  // gating change restarts the sequence; set beats clear
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      rebuild <= 1'b0;
      prev_active <= 1'b0;
    end
    else
    begin
      prev_active <= active;
      if (active != prev_active || mode != prev_mode)
        rebuild <= 1'b1;
      else if (ms_tick)
        rebuild <= 1'b0;
    end
  end

  // one transmission per ms tick, winner only
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      tx_valid <= 1'b0;
      tx_slot <= 4'h0;
      tx_ptype <= 3'h0;
      tx_power <= 5'h00;
      tx_gate <= 2'h0;
    end
    else
    begin
      tx_valid <= ms_tick && !rebuild && (|due);
      if (ms_tick && (|due))
      begin
        tx_slot <= win;
        tx_ptype <= slot_cfg[win][`BMC_TYPE_LSB +: 3];
        tx_power <= slot_cfg[win][`BMC_PWR_LSB +: 5];
        tx_gate <= slot_cfg[win][`BMC_GATE_LSB +: 2];
      end
    end
  end

  // -----------------------------------------------------------
  // event qualification
  // -----------------------------------------------------------
  logic saw_neg, flip_e, cfg_fire, act_go;
  assign flip_e = saw_neg && pos_e && !conn_open;
  assign cfg_fire = ctrl[`BMC_CTRL_CFG_FLIP] ? flip_e : cfg_src_e;
  assign act_go = act_e && !conn_open && (mode == st_beacon);
  assign accel_irq_mask = conn_open;

  // remember gravity along minus z
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      saw_neg <= 1'b0;
    else if (neg_lvl && !conn_open)
      saw_neg <= 1'b1;
    else if (pos_e)
      saw_neg <= 1'b0;
  end

  // -----------------------------------------------------------
  // timers
  // -----------------------------------------------------------
  logic [31:0] act_ms, cfg_ms;
  logic act_pend, cfg_pend, cfg_exp;

  // activity flag and timer
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      active <= 1'b0;
      act_ms <= 32'h0000_0000;
      act_pend <= 1'b0;
    end
    else if (mode != st_beacon)
    begin
      active <= 1'b0;
      act_ms <= 32'h0000_0000;
      act_pend <= 1'b0;
    end
    else if (act_go)
    begin
      active <= 1'b1;
      act_ms <= act_to;
    end
    else if (drop_e && conn_open && act_pend)
    begin
      active <= 1'b0;
      act_pend <= 1'b0;
    end
    else if (ms_tick && active && act_ms != 32'h0000_0000)
    begin
      act_ms <= act_ms - 32'h0000_0001;
      if (act_ms == 32'h0000_0001)
      begin
        // expiry on the drop edge itself is applied at once, not parked
        if (conn_open && !drop_e)
          act_pend <= 1'b1;
        else
          active <= 1'b0;
      end
    end
  end

  // configuration timer
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      cfg_ms <= 32'h0000_0000;
      cfg_pend <= 1'b0;
      cfg_exp <= 1'b0;
    end
    else
    begin
      cfg_exp <= 1'b0;
      if (mode != st_config)
      begin
        cfg_ms <= 32'h0000_0000;
        cfg_pend <= 1'b0;
      end
      else if (prev_mode != st_config)
        cfg_ms <= cfg_to;
      else if (ms_tick && cfg_ms != 32'h0000_0000)
      begin
        cfg_ms <= cfg_ms - 32'h0000_0001;
        if (cfg_ms == 32'h0000_0001)
        begin
          // expiry on the drop edge itself is applied at once, not parked
          if (conn_open && !drop_e)
            cfg_pend <= 1'b1;
          else
            cfg_exp <= 1'b1;
        end
      end
    end
  end

  // -----------------------------------------------------------
  // mode machine and connection
  // -----------------------------------------------------------
  bmc_mode_e start_mode;
  logic [3:0] power_on_self_test_ms;
  logic led_go, led_grn, led_hold_req;
  logic [1:0] led_n;
  assign start_mode = ctrl[`BMC_CTRL_START_WH] ? st_warehouse : st_beacon;

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      mode <= st_power_on_self_test;
      prev_mode <= st_power_on_self_test;
      locked <= 1'b0;
      conn_open <= 1'b0;
      conn_accept <= 1'b0;
      conn_term <= 1'b0;
      power_on_self_test_ms <= 4'h0;
      led_go <= 1'b0;
      led_grn <= 1'b0;
      led_n <= 2'h0;
      led_hold_req <= 1'b0;
    end
    else
    begin
      prev_mode <= mode;
      conn_accept <= 1'b0;
      conn_term <= 1'b0;
      led_go <= 1'b0;
      led_hold_req <= 1'b0;
      if (reset_e)
      begin
        mode <= st_power_on_self_test;
        locked <= 1'b0;
        conn_open <= 1'b0;
        power_on_self_test_ms <= 4'h0;
      end
      else if (conn_open)
      begin
        if (btn_e)
          conn_term <= 1'b1;
        if (drop_e)
        begin
          conn_open <= 1'b0;
          if (cfg_pend)
          begin
            mode <= start_mode;
            led_go <= 1'b1;
            led_grn <= 1'b0;
            led_n <= 2'h2;
          end
        end
      end
      else if (req_e && (mode == st_config || (|conn_adv)))
      begin
        conn_open <= 1'b1;
        conn_accept <= 1'b1;
      end
      else
      begin
        case (mode)
          st_power_on_self_test:
          begin
            if (ms_tick)
              power_on_self_test_ms <= power_on_self_test_ms + 4'h1;
            if (ms_tick && power_on_self_test_ms == 4'(`BMC_POWER_ON_SELF_TEST_MS - 1))
              mode <= fail_lvl ? st_config : start_mode;
          end
          st_warehouse, st_beacon:
          begin
            if (lock_e)
            begin
              mode <= st_beacon;
              locked <= 1'b1;
              led_go <= 1'b1;
              led_grn <= 1'b1;
              led_n <= 2'h3;
            end
            else if (cfg_fire)
            begin
              mode <= st_config;
              led_go <= 1'b1;
              led_grn <= 1'b1;
              led_n <= 2'h2;
            end
            else if (onoff_e && !locked && mode == st_beacon)
            begin
              mode <= st_warehouse;
              led_hold_req <= 1'b1;
            end
            else if (onoff_e && !locked)
            begin
              mode <= st_beacon;
              led_go <= 1'b1;
              led_grn <= 1'b1;
              led_n <= 2'h1;
            end
          end
          st_config:
          begin
            if (lock_e)
            begin
              mode <= st_beacon;
              locked <= 1'b1;
              led_go <= 1'b1;
              led_grn <= 1'b1;
              led_n <= 2'h3;
            end
            else if (onoff_e && !locked)
            begin
              mode <= st_beacon;
              led_go <= 1'b1;
              led_grn <= 1'b0;
              led_n <= 2'h2;
            end
            else if (cfg_exp)
            begin
              mode <= start_mode;
              led_go <= 1'b1;
              led_grn <= 1'b0;
              led_n <= 2'h2;
            end
          end
          default:
            mode <= st_power_on_self_test;
        endcase
      end
    end
  end

  // -----------------------------------------------------------
  // indicator sequencer
  // -----------------------------------------------------------
  logic [15:0] led_ms;
  logic [1:0] led_left;
  logic lamp_grn;
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      led_st <= led_idle;
      led_ms <= 16'h0000;
      led_left <= 2'h0;
      lamp_grn <= 1'b0;
      led_red <= 1'b0;
      led_green <= 1'b0;
    end
    else
    begin
      led_red <= (led_st == led_hold) || (led_st == led_on && !lamp_grn);
      led_green <= (led_st == led_on) && lamp_grn;
      if (ms_tick && led_ms != 16'h0000)
        led_ms <= led_ms - 16'h0001;
      if (led_hold_req)
      begin
        led_st <= led_hold;
        led_ms <= 16'(`BMC_HOLD_MS);
      end
      else if (led_go)
      begin
        led_st <= led_on;
        led_ms <= 16'(`BMC_FLASH_MS);
        led_left <= led_n;
        lamp_grn <= led_grn;
      end
      else if (led_ms == 16'h0000)
      begin
        case (led_st)
          led_on:
          begin
            led_st <= (led_left == 2'h1) ? led_idle : led_gap;
            led_left <= led_left - 2'h1;
            led_ms <= 16'(`BMC_FLASH_MS);
          end
          led_gap:
          begin
            led_st <= led_on;
            led_ms <= 16'(`BMC_FLASH_MS);
          end
          default:
            led_st <= led_idle;
        endcase
      end
    end
  end

  // -----------------------------------------------------------
  // checks
  // -----------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence s_free;
    !reset_e && !conn_open && !lock_e && !req_e;
  endsequence

  tx_in_beacon_a: assert property (tx_valid |-> $past(mode) == st_beacon)
    else $error("transmission outside beaconing");
  tx_gate_on_a: assert property (tx_valid |-> tx_gate != gate_off)
    else $error("slot gated off transmitted");
  tx_act_only_a: assert property (tx_valid && tx_gate == gate_active |-> $past(active))
    else $error("active slot sent while inactive");
  tx_inact_only_a: assert property (tx_valid && tx_gate == gate_inactive |-> !$past(active))
    else $error("inactive slot sent while active");
  cfg_entry_a: assert property (s_free ##0 (mode inside {st_beacon, st_warehouse}) && cfg_fire
    |=> mode == st_config && led_go && led_grn && led_n == 2'h2)
    else $error("configuration event not taken");
  btn_term_a: assert property (conn_open && btn_e && !reset_e |=> conn_term)
    else $error("button did not end connection");
  power_on_self_test_back_a: assert property (reset_e |=> mode == st_power_on_self_test ##1 mode == st_power_on_self_test)
    else $error("reset did not return to self-test");
  act_start_a: assert property (act_go |=> active && act_ms == $past(act_to))
    else $error("activity timer not started");
  mask_conn_a: assert property ($rose(conn_open) |-> accel_irq_mask && $past(req_e))
    else $error("accelerometer not masked");
  act_mask_a: assert property (conn_open |=> !$rose(active))
    else $error("activity taken while connected");
endmodule

`default_nettype wire

// *** bmc_central.sv ***
`timescale 1ns/1ns
`default_nettype none
// ----
// radio central model
// ----
module bmc_central (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // beacon side
  input wire logic tx_valid,
  input wire logic [2:0] tx_ptype,
  input wire logic conn_term,
  // bench control
  input wire logic want,
  input wire logic [3:0] lag,
  // link events
  output logic conn_req,
  output logic conn_drop
);
  int cnt;
  int dcnt;
  // connect on a connectable advert, after lag
  always_ff @(posedge clk)
    if (!rst_b)
      cnt <= 0;
    else if (cnt > 0)
      cnt <= cnt - 1;
    else if (want && tx_valid && tx_ptype == 3'h5)
      cnt <= 8 + lag;
  assign conn_req = cnt > 0 && cnt < 5;
  // leave when the beacon asks to end
  always_ff @(posedge clk)
    if (!rst_b)
      dcnt <= 0;
    else if (conn_term)
      dcnt <= 4;
    else if (dcnt > 0)
      dcnt <= dcnt - 1;
  assign conn_drop = dcnt > 0;
endmodule
`default_nettype wire

// *** testbench.sv ***
`timescale 1ns/1ns
`default_nettype none
// ----
// bench
// ----
module testbench;
  logic clk = 0;
  logic rst_b = 0;
  logic [7:0] adr = 0;
  logic rd = 0;
  logic wr = 0;
  logic [31:0] wd = 0;
  logic [31:0] rdat, q, pw;
  logic abort = 0;
  int n_acc = 0;
  logic [31:0] seed = 97;
  logic wrq, acc, term, mask, txv, lr, lg, creq, cdrop;
  logic [3:0] tslot, ob;
  logic [3:0] lag = 0;
  logic [2:0] tpt;
  logic [4:0] tpw;
  logic [8:0] ev = 0;
  logic want = 0;
  int n_mismatch = 0;
  int checked = 0;
  int mode_m, k;
  int cnt [16];
  always #10 clk = ~clk;
  assign ob = {term, mask, lg, lr};
  bmc_top #(.MS_CYC(10)) u_bmc_top (.clk(clk), .rst_b(rst_b), .avs_address(adr),
    .avs_read(rd), .avs_write(wr), .avs_writedata(wd), .avs_readdata(rdat),
    .avs_waitrequest(wrq), .btn_press(ev[0]), .act_det(ev[1]), .grav_neg_z(ev[2]),
    .grav_pos_z(ev[3]), .cfg_src_evt(ev[4]), .onoff_evt(ev[5]), .lock_evt(ev[6]),
    .reset_evt(ev[7]), .st_fail(ev[8]), .conn_req(creq), .conn_drop(cdrop),
    .conn_accept(acc), .conn_term(term), .accel_irq_mask(mask), .tx_valid(txv),
    .tx_slot(tslot), .tx_ptype(tpt), .tx_power(tpw), .led_red(lr), .led_green(lg));
  bmc_central u_bmc_central (.clk(clk), .rst_b(rst_b), .tx_valid(txv), .tx_ptype(tpt),
    .conn_term(term), .want(want), .lag(lag), .conn_req(creq), .conn_drop(cdrop));
  // per-slot advert counts and accepted connections
  always @(posedge clk)
  begin
    if (txv === 1'b1)
      cnt[tslot]++;
    if (acc === 1'b1)
      n_acc++;
  end
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task final_report;
    $display("mismatches %0d checks %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task cmp(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("BAD t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  // one bus cycle, held until waitrequest is sampled low at a rising edge
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    adr <= a;
    wd <= d;
    rd <= !w;
    wr <= w;
    @(posedge clk);
    for (i = 0; i < 20 && wrq !== 1'b0; i++)
      @(posedge clk);
    if (wrq !== 1'b0)
    begin
      n_mismatch++;
      abort = 1;
    end
    q = rdat;
    rd <= 0;
    wr <= 0;
    @(posedge clk);
  endtask
  // bounded wait for an output level
  task hit(input int b, input int n, input logic v);
    for (int i = 0; i < n && ob[b] !== v; i++)
      @(negedge clk);
    if (ob[b] !== v)
      abort = 1;
    cmp(ob[b], v);
    @(posedge clk);
  endtask
  task pulse(input int b);
    ev[b] <= 1;
    repeat (4) @(posedge clk);
    ev[b] <= 0;
    repeat (6) @(posedge clk);
  endtask
  task stat;
    bus(0, 8'h04, 0);
    cmp(q & 32'h0000_000F, mode_m);
  endtask
  task cnts(input int a, input int b, input int c);
    cnt = '{default: 0};
    repeat (400) @(posedge clk);
    cmp(cnt[0] > 0, a);
    cmp(cnt[1] > 0, b);
    cmp(cnt[2] > 0, c);
  endtask
  initial
  begin
    for (int i = 0; i < 100000 && !abort; i++)
      @(posedge clk);
    if (!abort)
      n_mismatch++;
    final_report;
  end
  initial
  begin
    repeat (3) @(posedge clk);
    rst_b <= 1;
    mode_m = 1;
    @(posedge clk);
    stat();
    bus(0, 8'h08, 0);
    cmp(q, 32'h0000_EA60);
    bus(0, 8'h0C, 0);
    cmp(q, 32'h0000_7530);
    for (k = 0; k < 11; k++)
    begin
      bus(0, 8'h40 + 8'(4 * k), 0);
      cmp(q, 0);
    end
    // slots set up during self-test so beaconing opens with a rebuild
    pw = 32'h0000_1015 | (xs() & 32'h0000_03E0);
    bus(1, 8'h0C, 60);
    bus(1, 8'h40, pw);
    bus(1, 8'h44, 32'h0000_1003);
    bus(1, 8'h48, 32'h0000_1002);
    for (k = 0; k < 200 && txv !== 1'b1; k++)
      @(negedge clk);
    if (txv !== 1'b1)
    begin
      n_mismatch++;
      abort = 1;
    end
    cmp(tslot, 0);
    cmp(tpw, pw[9:5]);
    cmp(tpt, 3'h5);
    @(posedge clk);
    mode_m = 8;
    stat();
    cnts(1, 1, 0);
    pulse(1);
    bus(0, 8'h04, 0);
    cmp(q[4], 1);
    cnts(1, 0, 1);
    repeat (400) @(posedge clk);
    bus(0, 8'h04, 0);
    cmp(q[4], 0);
    want <= 1;
    lag <= 4'(xs());
    hit(2, 300, 1);
    want <= 0;
    pulse(1);
    bus(0, 8'h04, 0);
    cmp(q[4], 0);
    cmp(n_acc, 1);
    ev[0] <= 1;
    hit(3, 20, 1);
    ev[0] <= 0;
    hit(2, 50, 0);
    stat();
    bus(1, 8'h08, 20);
    pulse(4);
    mode_m = 4;
    hit(1, 50, 1);
    stat();
    hit(0, 300, 1);
    mode_m = 8;
    stat();
    bus(1, 8'h00, 2);
    pulse(3);
    stat();
    ev[2] <= 1;
    repeat (10) @(posedge clk);
    ev[2] <= 0;
    pulse(3);
    mode_m = 4;
    stat();
    pulse(5);
    mode_m = 8;
    hit(0, 50, 1);
    stat();
    pulse(5);
    mode_m = 2;
    stat();
    pulse(5);
    mode_m = 8;
    hit(1, 50, 1);
    pulse(6);
    pulse(5);
    stat();
    pulse(7);
    mode_m = 1;
    stat();
    final_report;
  end
endmodule
`default_nettype wire
